// ### design/fpc_consts.svh
`ifndef FPC_CONSTS_SVH
`define FPC_CONSTS_SVH

// register word addresses on the plain port
`define FPC_ADDR_CONTROL 4'h0
`define FPC_ADDR_KEY 4'h1
`define FPC_ADDR_TARGET 4'h2
`define FPC_ADDR_DATA0 4'h3
`define FPC_ADDR_DATA1 4'h4
`define FPC_ADDR_SRC 4'h5

// control register fields
`define FPC_BIT_START 15
`define FPC_BIT_START_WRITE_ENABLE 14
`define FPC_BIT_PERR 13
`define FPC_BIT_LVERR 12
`define FPC_OPSEL_MSB 3
`define FPC_OPSEL_LSB 0

// unlock keys
`define FPC_KEY_FIRST 32'haa996655
`define FPC_KEY_SECOND 32'h556699aa

// operation select codes
`define FPC_OP_CLEAR 4'h0
`define FPC_OP_DWORD 4'h2
`define FPC_OP_ROW 4'h3
`define FPC_OP_ERASE 4'h4

`define FPC_RESET_WORD 32'h00000000

`endif

// ### design/fpc_pkg.sv
`default_nettype none
package fpc_pkg;
  typedef enum logic [3:0] {
    FPC_IDLE = 4'b0001,
    FPC_ISSUE = 4'b0010,
    FPC_WAIT = 4'b0100,
    FPC_DONE = 4'b1000
  } fpc_state_t;

  typedef enum logic [2:0] {
    FPC_KEY_NONE = 3'b001,
    FPC_KEY_HALF = 3'b010,
    FPC_KEY_OPEN = 3'b100
  } fpc_key_state_t;
endpackage
`default_nettype wire

// ### design/fpc_unlock_if.sv
`timescale 1ns/1ps
`default_nettype none
interface fpc_unlock_if;
  logic key_wr;
  logic other_access;
  logic [31:0] key_data;
  logic consume;
  logic unlocked;
  modport ctrl (output key_wr, output other_access, output key_data, output consume,
    input unlocked);
  modport unlock (input key_wr, input other_access, input key_data, input consume,
    output unlocked);
endinterface
`default_nettype wire

// ### design/fpc_unlock.sv
`timescale 1ns/1ps
`default_nettype none
`include "fpc_consts.svh"
module fpc_unlock (
  // clock and power-on reset
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  // control side
  fpc_unlock_if.unlock bus
);
  import fpc_pkg::*;

  fpc_key_state_t state_reg;

  // [R15] two key writes
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      state_reg <= FPC_KEY_NONE;
    end else if (bus.consume || bus.other_access) begin
      state_reg <= FPC_KEY_NONE;
    end else if (bus.key_wr) begin
      case (state_reg)
        FPC_KEY_NONE: begin
          state_reg <= (bus.key_data == `FPC_KEY_FIRST) ? FPC_KEY_HALF : FPC_KEY_NONE;
        end
        FPC_KEY_HALF: begin
          state_reg <= (bus.key_data == `FPC_KEY_SECOND) ? FPC_KEY_OPEN : FPC_KEY_NONE;
        end
        default: begin
          state_reg <= FPC_KEY_NONE;
        end
      endcase
    end
  end

  assign bus.unlocked = (state_reg == FPC_KEY_OPEN);
endmodule
`default_nettype wire

// ### design/fpc_flash_program_controller.sv
// What this block does
// [R01] the start bit is set only with start-write enable high right after unlock, never cleared by software.
// [R02] setting start launches the selected operation and hardware clears start when done.
// [R03] with start-write enable high, start writes are taken and operation select writes ignored.
// [R04] with start-write enable low, start writes are ignored and operation select writes taken.
// [R05] hardware sets the program-error flag on a failed program or erase, software cannot write it.
// [R06] hardware sets the low-voltage flag when supply is too low, software cannot write it; here it is set only in FPC_ISSUE or FPC_WAIT.
// [R07] both error flags clear only by launching an operation with operation select all zero.
// [R08] unused control bits read zero and reserved bit 11 is held at zero.
// [R09] start, start-write enable and the error flags reset only on power-on reset.
// [R10] double-word program writes data word 1 and data word 0 to the target address.
// [R11] data word 0 is the low instruction word, data word 1 the high one.
// [R12] row program fetches its data from the source address register.
// [R13] data words and source address are read/write and reset only on power-on reset.
// [R14] operation select is a 4-bit read/write field in control bits 3:0.
// [R15] unlock is two key writes right before setting start, any other access voids it.
// [R16] codes exist for double-word, row program, erase and the all-zero clear.
//
// The implementer's own choices: the address map and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "fpc_consts.svh"
module fpc_flash_program_controller (
  // clock and power-on reset
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  // register port
  input wire logic [3:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  // flash array request
  output logic flash_req_o,
  output logic [3:0] flash_op_o,
  output logic [31:0] flash_addr_o,
  output logic [63:0] flash_wdata_o,
  output logic [31:0] flash_src_addr_o,
  input wire logic flash_done_i,
  input wire logic flash_fail_i,
  // supply monitor pin
  input wire logic low_voltage_i
);
  import fpc_pkg::*;

  fpc_state_t state_reg;
  logic start_reg;
  logic start_write_enable_reg;
  logic perr_reg;
  logic lverr_reg;
  logic [3:0] opsel_reg;
  logic [31:0] target_reg;
  logic [31:0] data0_reg;
  logic [31:0] data1_reg;
  logic [31:0] src_reg;
  logic [2:0] lv_sync_reg;
  logic lv_stable_reg;
  logic ctrl_wr;
  logic launch;
  logic op_is_clear;
  logic unlocked;

  fpc_unlock_if ulk ();

  fpc_unlock u_unlock (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .bus(ulk.unlock)
  );

  assign ctrl_wr = reg_wr_i && (reg_addr_i == `FPC_ADDR_CONTROL);
  assign unlocked = ulk.unlocked;
  // [R15] key writes and voiding accesses
  assign ulk.key_wr = reg_wr_i && (reg_addr_i == `FPC_ADDR_KEY);
  assign ulk.key_data = reg_wdata_i;
  assign ulk.other_access = (reg_wr_i || reg_rd_i) && !ulk.key_wr && !ctrl_wr;
  assign ulk.consume = ctrl_wr;

  // [R01] start set gate
  assign launch = ctrl_wr && start_write_enable_reg && unlocked && reg_wdata_i[`FPC_BIT_START]
    && !start_reg && (state_reg == FPC_IDLE);
  assign op_is_clear = (opsel_reg == `FPC_OP_CLEAR);

  // low-voltage pin: three stages, change taken when last two agree
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      lv_sync_reg <= 3'h0;
      lv_stable_reg <= 1'b0;
    end else begin
      lv_sync_reg <= {lv_sync_reg[1:0], low_voltage_i};
      if (lv_sync_reg[2] == lv_sync_reg[1]) begin
        lv_stable_reg <= lv_sync_reg[2];
      end
    end
  end

  // [R09] sys_rst_i is the power-on reset
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      start_write_enable_reg <= 1'b0;
      opsel_reg <= 4'h0;
    end else if (ctrl_wr) begin
      start_write_enable_reg <= reg_wdata_i[`FPC_BIT_START_WRITE_ENABLE];
      // [R03] [R04] [R14] select writable only with enable low
      if (!start_write_enable_reg) begin
        opsel_reg <= reg_wdata_i[`FPC_OPSEL_MSB:`FPC_OPSEL_LSB];
      end
    end
  end

  // [R02] operation sequencer
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      state_reg <= FPC_IDLE;
      start_reg <= 1'b0;
    end else begin
      case (state_reg)
        FPC_IDLE: begin
          if (launch) begin
            start_reg <= 1'b1;
            state_reg <= op_is_clear ? FPC_DONE : FPC_ISSUE;
          end
        end
        FPC_ISSUE: begin
          state_reg <= FPC_WAIT;
        end
        FPC_WAIT: begin
          if (flash_done_i) begin
            state_reg <= FPC_DONE;
          end
        end
        FPC_DONE: begin
          start_reg <= 1'b0;
          state_reg <= FPC_IDLE;
        end
        default: begin
          state_reg <= FPC_IDLE;
          start_reg <= 1'b0;
        end
      endcase
    end
  end

  // [R05] [R06] [R07] sticky error flags, set wins over clear
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      perr_reg <= 1'b0;
      lverr_reg <= 1'b0;
    end else begin
      if (state_reg == FPC_WAIT && flash_done_i && flash_fail_i) begin
        perr_reg <= 1'b1;
      end else if (launch && op_is_clear) begin
        perr_reg <= 1'b0;
      end
      if (state_reg != FPC_IDLE && state_reg != FPC_DONE && lv_stable_reg) begin
        lverr_reg <= 1'b1;
      end else if (launch && op_is_clear) begin
        lverr_reg <= 1'b0;
      end
    end
  end

  // [R13] data and address registers
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      target_reg <= `FPC_RESET_WORD;
      data0_reg <= `FPC_RESET_WORD;
      data1_reg <= `FPC_RESET_WORD;
      src_reg <= `FPC_RESET_WORD;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        `FPC_ADDR_TARGET: target_reg <= reg_wdata_i;
        `FPC_ADDR_DATA0: data0_reg <= reg_wdata_i;
        `FPC_ADDR_DATA1: data1_reg <= reg_wdata_i;
        `FPC_ADDR_SRC: src_reg <= reg_wdata_i;
        default: begin
        end
      endcase
    end
  end

  // flash request: a one-cycle pulse, operands held while busy
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      flash_req_o <= 1'b0;
      flash_op_o <= 4'h0;
      flash_addr_o <= `FPC_RESET_WORD;
      flash_wdata_o <= 64'h0;
      flash_src_addr_o <= `FPC_RESET_WORD;
    end else begin
      flash_req_o <= (state_reg == FPC_ISSUE);
      if (state_reg == FPC_ISSUE) begin
        // [R16] code passed to the array
        flash_op_o <= opsel_reg;
        flash_addr_o <= target_reg;
        // [R10] [R11] word 1 high, word 0 low
        flash_wdata_o <= {data1_reg, data0_reg};
        // [R12] row source address
        flash_src_addr_o <= src_reg;
      end
    end
  end

  // [R08] read mux, unused and reserved bits zero
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      reg_rdata_o <= 32'h0;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        `FPC_ADDR_CONTROL: reg_rdata_o <= {16'h0, start_reg, start_write_enable_reg, perr_reg, lverr_reg,
          8'h0, opsel_reg};
        `FPC_ADDR_TARGET: reg_rdata_o <= target_reg;
        `FPC_ADDR_DATA0: reg_rdata_o <= data0_reg;
        `FPC_ADDR_DATA1: reg_rdata_o <= data1_reg;
        `FPC_ADDR_SRC: reg_rdata_o <= src_reg;
        default: reg_rdata_o <= 32'h0;
      endcase
    end else begin
      reg_rdata_o <= 32'h0;
    end
  end
endmodule
`default_nettype wire

// ### tb/fpc_flash_model.sv
`timescale 1ns/1ps
`default_nettype none
module fpc_flash_model (
  // clock
  input wire logic sys_clk_i,
  // request side
  input wire logic req_i,
  input wire logic [7:0] lat_i,
  input wire logic fail_cmd_i,
  // answer
  output logic done_o,
  output logic fail_o
);
  logic [7:0] cnt_reg = 8'h00;
  logic busy_reg = 1'b0;
  initial done_o = 1'b0;
  initial fail_o = 1'b0;
  // fail toggles outside done so a stale level never passes for an answer
  always @(posedge sys_clk_i) begin
    done_o <= 1'b0;
    fail_o <= ~fail_o;
    if (req_i) begin
      busy_reg <= 1'b1;
      cnt_reg <= lat_i;
    end else if (busy_reg && cnt_reg == 8'h00) begin
      busy_reg <= 1'b0;
      done_o <= 1'b1;
      fail_o <= fail_cmd_i;
    end else if (busy_reg) begin
      cnt_reg <= cnt_reg - 8'h01;
    end
  end
endmodule
`default_nettype wire

// ### tb/fpc_assertions.sv
`timescale 1ns/1ps
`default_nettype none
`include "fpc_consts.svh"
module fpc_assertions (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  // register port
  input wire logic [3:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  // flash side
  input wire logic flash_req_o,
  input wire logic flash_done_i,
  input wire logic flash_fail_i
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  logic cw, cr, k1, k2, sw;
  assign cw = reg_wr_i && reg_addr_i == `FPC_ADDR_CONTROL;
  assign cr = reg_rd_i && reg_addr_i == `FPC_ADDR_CONTROL;
  assign k1 = reg_wr_i && reg_addr_i == `FPC_ADDR_KEY && reg_wdata_i == `FPC_KEY_FIRST;
  assign k2 = reg_wr_i && reg_addr_i == `FPC_ADDR_KEY && reg_wdata_i == `FPC_KEY_SECOND;
  assign sw = cw && reg_wdata_i[15];
  sequence unlock_start;
    cw && reg_wdata_i[14] ##1 k1 ##1 k2 ##1 sw;
  endsequence
  sequence done_then_read;
    flash_done_i ##3 cr;
  endsequence
  sequence fail_then_read;
    flash_done_i && flash_fail_i ##3 cr;
  endsequence
  sequence write_then_read;
    reg_wr_i && reg_addr_i inside {`FPC_ADDR_DATA0, `FPC_ADDR_DATA1, `FPC_ADDR_SRC}
      ##1 reg_rd_i && $stable(reg_addr_i);
  endsequence
  AST_CTRL_ZERO: assert property ($past(cr) |-> reg_rdata_o[31:16] == 16'h0
    && reg_rdata_o[11:4] == 8'h0)
    else $error("control read shows unused bits set");
  AST_REQ_PULSE: assert property (flash_req_o |=> !flash_req_o)
    else $error("request longer than one cycle");
  AST_REQ_CAUSE: assert property (flash_req_o |-> $past(sw, 2) && $past(k2, 3))
    else $error("request without unlocked start write");
  AST_LAUNCH: assert property (unlock_start ##1 cr |=> reg_rdata_o[15])
    else $error("start not set after unlock");
  AST_BUSY_READ: assert property (flash_req_o && cr |=> reg_rdata_o[15])
    else $error("start low during request");
  AST_DONE_CLEARS: assert property (done_then_read |=> !reg_rdata_o[15])
    else $error("start still set after done");
  AST_FAIL_FLAG: assert property (fail_then_read |=> reg_rdata_o[13])
    else $error("program error flag not set");
  AST_RW_BACK: assert property (write_then_read |=> reg_rdata_o == $past(reg_wdata_i, 2))
    else $error("register read back differs");
endmodule
bind fpc_flash_program_controller fpc_assertions u_chk (.sys_clk_i, .sys_rst_i, .reg_addr_i,
  .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .flash_req_o, .flash_done_i, .flash_fail_i);
`default_nettype wire

// ### tb/fpc_flash_program_controller_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "fpc_consts.svh"
module fpc_flash_program_controller_bench;
  logic sys_clk_i = 1'b0, sys_rst_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
  logic [3:0] reg_addr_i = 4'h0, flash_op_o;
  logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o, flash_addr_o, flash_src_addr_o, rq;
  logic flash_req_o, flash_done_i, flash_fail_i, low_voltage_i = 1'b0, fail_cmd = 1'b0;
  logic pe = 1'b0, lv = 1'b0;
  logic [63:0] flash_wdata_o;
  logic [7:0] lat = 8'h00;
  logic [3:0] al [6] = '{4'h0, 4'h2, 4'h3, 4'h4, 4'h5, 4'hf};
  int miscompares = 0, cmp_count = 0, reqs = 0, cyc = 0;
  fpc_flash_program_controller u_dut (.sys_clk_i, .sys_rst_i, .reg_addr_i, .reg_wdata_i,
    .reg_wr_i, .reg_rd_i, .reg_rdata_o, .flash_req_o, .flash_op_o, .flash_addr_o,
    .flash_wdata_o, .flash_src_addr_o, .flash_done_i, .flash_fail_i, .low_voltage_i);
  fpc_flash_model u_mem (.sys_clk_i, .req_i(flash_req_o), .lat_i(lat), .fail_cmd_i(fail_cmd),
    .done_o(flash_done_i), .fail_o(flash_fail_i));
  always #2.5 sys_clk_i = ~sys_clk_i;
  // hang guard, the whole run needs fewer than two hundred cycles
  always @(posedge sys_clk_i) begin
    reqs <= reqs + int'(flash_req_o);
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      miscompares++;
      finish_test();
    end
  end
  task automatic chk(input logic [63:0] s, input logic [63:0] e);
    cmp_count++;
    if (s !== e) begin
      miscompares++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  // read data of the previous cycle is caught mid-cycle, where it stands
  task automatic xf(input logic w, input logic r, input logic [3:0] a, input logic [31:0] d);
    reg_wr_i <= w;
    reg_rd_i <= r;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(negedge sys_clk_i) rq = reg_rdata_o;
    @(posedge sys_clk_i);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    xf(1'b1, 1'b0, a, d);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    xf(1'b0, 1'b1, a, 32'h0);
    xf(1'b0, 1'b0, a, 32'h0);
    chk(rq, e);
  endtask
  task automatic go(input logic [3:0] op, input logic f, input logic v, input logic [7:0] lt);
    int n0;
    n0 = reqs;
    fail_cmd <= f;
    low_voltage_i <= v;
    lat <= lt;
    wr(`FPC_ADDR_CONTROL, 32'h0);
    wr(`FPC_ADDR_CONTROL, 32'h4000 | op);
    wr(`FPC_ADDR_KEY, `FPC_KEY_FIRST);
    wr(`FPC_ADDR_KEY, `FPC_KEY_SECOND);
    wr(`FPC_ADDR_CONTROL, 32'hc000);
    xf(1'b0, 1'b1, `FPC_ADDR_CONTROL, 32'h0);
    xf(1'b0, 1'b1, `FPC_ADDR_CONTROL, 32'h0);
    chk(rq[15], 1'b1);
    while (rq[15] === 1'b1) xf(1'b0, 1'b1, `FPC_ADDR_CONTROL, 32'h0);
    xf(1'b0, 1'b0, 4'h0, 32'h0);
    pe = (op == `FPC_OP_CLEAR) ? 1'b0 : pe | f;
    lv = (op == `FPC_OP_CLEAR) ? 1'b0 : lv | v;
    chk(rq, {16'h0, 2'b01, pe, lv, 8'h0, op});
    chk(reqs - n0, op != `FPC_OP_CLEAR);
    $display("operation %0h done", op);
  endtask
  task automatic finish_test();
    $display("compares %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic reg_test();
    logic [31:0] ex;
    foreach (al[i]) rd(al[i], 32'h0);
    foreach (al[i]) begin
      wr(al[i], 32'hffffffff);
      ex = (al[i] == 4'h0) ? 32'h400f : (al[i] == 4'hf) ? 32'h0 : 32'hffffffff;
      rd(al[i], ex);
    end
    wr(`FPC_ADDR_CONTROL, 32'h0);
    rd(`FPC_ADDR_CONTROL, 32'hf);
    wr(`FPC_ADDR_CONTROL, 32'h8000);
    rd(`FPC_ADDR_CONTROL, 32'h0);
    // a real operation selected, so a wrongful launch shows as a request
    wr(`FPC_ADDR_CONTROL, 32'h4000 | `FPC_OP_DWORD);
    wr(`FPC_ADDR_KEY, `FPC_KEY_FIRST);
    wr(`FPC_ADDR_KEY, `FPC_KEY_SECOND);
    rd(`FPC_ADDR_DATA0, 32'hffffffff);
    wr(`FPC_ADDR_CONTROL, 32'hc000);
    rd(`FPC_ADDR_CONTROL, 32'h4000 | `FPC_OP_DWORD);
    chk(reqs, 0);
    $display("register tests done");
  endtask
  task automatic op_test();
    wr(`FPC_ADDR_DATA0, 32'h12345678);
    wr(`FPC_ADDR_DATA1, 32'h9abcdef0);
    wr(`FPC_ADDR_TARGET, 32'h1000);
    wr(`FPC_ADDR_SRC, 32'h20000040);
    go(`FPC_OP_DWORD, 1'b0, 1'b0, 8'h00);
    chk(flash_wdata_o, 64'h9abcdef0_12345678);
    chk(flash_addr_o, 32'h1000);
    go(`FPC_OP_ROW, 1'b1, 1'b0, 8'h10);
    chk(flash_src_addr_o, 32'h20000040);
    chk(flash_op_o, `FPC_OP_ROW);
    go(`FPC_OP_ERASE, 1'b0, 1'b1, 8'h10);
    go(`FPC_OP_CLEAR, 1'b0, 1'b0, 8'h00);
    $display("operation tests done");
  endtask
  initial begin
    repeat (2) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    reg_test();
    op_test();
    finish_test();
  end
endmodule
`default_nettype wire
